// file: hdl/bcd_adc_map.svh
`ifndef BCD_ADC_MAP_SVH
`define BCD_ADC_MAP_SVH

// ****************************************************************
// Clock and conversion timing
// ****************************************************************
`define CLK_KHZ 100000
`define CONV_MS_SMALL 200
`define CONV_MS_LARGE 400

// ****************************************************************
// Result range and codes
// ****************************************************************
`define FS_COUNTS_SMALL 12'h7D0
`define FS_COUNTS_LARGE 12'hFA0
`define OVR_DIGIT 4'hE
`define RESET_DIGIT 4'h0

// ****************************************************************
// Host port layout
// ****************************************************************
`define PORT_BASE_DEFAULT 6'h10
`define ADDR_BASE_LSB 2
`define OFL_BIT 7
`define SIGN_BIT 6
`define SEL_DIGIT4 2'h3

`endif

// file: hdl/bcd_adc_pkg.sv
package bcd_adc_pkg;

    // Result from the modulator: polarity plus binary magnitude
    typedef struct packed {
        logic negative;
        logic [11:0] magnitude;
    } sample_s;

    // Four BCD digits, digit 4 most significant
    typedef struct packed {
        logic [3:0] d4;
        logic [3:0] d3;
        logic [3:0] d2;
        logic [3:0] d1;
    } digits_s;

    // One host bus cycle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } host_req_s;

    typedef enum logic [1:0] {
        st_idle,
        st_converting,
        st_encoding
    } conv_state_e;

endpackage : bcd_adc_pkg

// file: hdl/bcd_encoder.sv
`timescale 1ns/100ps
`default_nettype none

module bcd_encoder #(
    parameter int BIN_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [BIN_W-1:0] value,
    output logic busy,
    output logic done,
    output bcd_adc_pkg::digits_s digits
);
    import bcd_adc_pkg::*;

    logic [16+BIN_W-1:0] shreg;
    logic [15:0] adjusted;
    logic [4:0] bits_left;

    // ****************************************************************
    // Add-three correction, one per digit
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_adj
            assign adjusted[4*g +: 4] = (shreg[BIN_W+4*g +: 4] >= 4'h5) ?
                shreg[BIN_W+4*g +: 4] + 4'h3 : shreg[BIN_W+4*g +: 4];
        end
    endgenerate

    // ****************************************************************
    // Shift-and-add sequencer
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shreg <= '0;
            bits_left <= 5'h00;
            busy <= 1'b0;
        end else if (start) begin
            shreg <= {16'h0000, value};
            bits_left <= 5'(BIN_W);
            busy <= 1'b1;
        end else if (busy) begin
            shreg <= {adjusted[14:0], shreg[BIN_W-1:0], 1'b0};
            bits_left <= bits_left - 5'h01;
            busy <= (bits_left != 5'h01);
        end
    end

    // Result register, updated once the last shift is done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            digits <= '0;
            done <= 1'b0;
        end else begin
            // Busy drops with the last shift, so take the digits from the adders then
            done <= busy && (bits_left == 5'h01);
            if (busy && (bits_left == 5'h01)) begin
                digits <= {adjusted[14:0], shreg[BIN_W-1]};
            end
        end
    end

endmodule : bcd_encoder

`default_nettype wire

// file: hdl/bcd_adc_host_port.sv
`include "bcd_adc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module bcd_adc_host_port #(
    parameter bit LARGE_RANGE = 1'b0,
    parameter int unsigned CONV_CYCLES =
        (LARGE_RANGE ? `CONV_MS_LARGE : `CONV_MS_SMALL) * `CLK_KHZ,
    parameter logic [5:0] PORT_BASE = `PORT_BASE_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic conversion_trigger,
    input wire logic digit_latch_enable,
    input wire logic [1:0] digit_address,
    input wire bcd_adc_pkg::sample_s sample,
    input wire bcd_adc_pkg::host_req_s host_req,
    output logic [3:0] digit_out,
    output logic sign_out,
    output logic overrange_flag,
    output logic conversion_done,
    output logic [7:0] host_rdata,
    output logic host_rdata_oe
);
    import bcd_adc_pkg::*;

    localparam logic [11:0] FULL_SCALE =
        LARGE_RANGE ? `FS_COUNTS_LARGE : `FS_COUNTS_SMALL;
    localparam logic [31:0] LAST_TICK = 32'(CONV_CYCLES - 1);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] trig_sync;
    logic [1:0] dle_sync;
    logic [1:0] addr_meta;
    logic [1:0] addr_sync;
    logic trig_prev;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trig_sync <= 2'h0;
        end else begin
            trig_sync <= {trig_sync[0], conversion_trigger};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dle_sync <= 2'h0;
        end else begin
            dle_sync <= {dle_sync[0], digit_latch_enable};
        end
    end

    // Address bits pass two stages before the selector reads them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_meta <= 2'h0;
            addr_sync <= 2'h0;
        end else begin
            addr_meta <= digit_address;
            addr_sync <= addr_meta;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_sync[1];
        end
    end

    // ****************************************************************
    // Host select gates
    // ****************************************************************
    logic port_hit;
    logic host_start;
    logic host_read;

    assign port_hit = (host_req.addr[7:`ADDR_BASE_LSB] == PORT_BASE);
    assign host_start = port_hit && host_req.wr;
    assign host_read = port_hit && host_req.rd;

    // ****************************************************************
    // Start requests
    // ****************************************************************
    logic trig_level;
    logic trig_rise;
    logic start_req;
    logic restart_req;

    assign trig_level = trig_sync[1];
    assign trig_rise = trig_sync[1] && !trig_prev;
    // Level or pulse from the pin, or a host write, starts a conversion
    assign start_req = trig_level || host_start;
    // A fresh pulse during a conversion restarts its timing
    assign restart_req = trig_rise || host_start;

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    conv_state_e state;
    conv_state_e next_state;
    logic [31:0] timer;
    logic timer_end;
    logic enc_start;
    logic enc_done;
    digits_s enc_digits;

    assign timer_end = (timer == LAST_TICK);

    always_comb begin
        next_state = state;
        case (state)
            st_idle: begin
                if (start_req) begin
                    next_state = st_converting;
                end
            end
            st_converting: begin
                if (!restart_req && timer_end) begin
                    next_state = st_encoding;
                end
            end
            st_encoding: begin
                if (enc_done) begin
                    next_state = st_idle;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // Conversion time counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timer <= 32'h00000000;
        end else if (state != st_converting || restart_req) begin
            timer <= 32'h00000000;
        end else if (!timer_end) begin
            timer <= timer + 32'h00000001;
        end
    end

    // ****************************************************************
    // Result capture
    // ****************************************************************
    logic cap_negative;
    logic cap_over;

    assign enc_start = (state == st_converting) && !restart_req && timer_end;

    // The modulator tracks all the time; only this capture and the encoder load at enc_start move data on
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cap_negative <= 1'b0;
            cap_over <= 1'b0;
        end else if (enc_start) begin
            cap_negative <= sample.negative;
            cap_over <= (sample.magnitude >= FULL_SCALE);
        end
    end

    bcd_encoder #(
        .BIN_W(12)
    ) u_encoder (
        .clk(ref_clk),
        .rst(rst),
        .start(enc_start),
        .value(sample.magnitude),
        .busy(),
        .done(enc_done),
        .digits(enc_digits)
    );

    // ****************************************************************
    // Output latches
    // ****************************************************************
    digits_s out_digits;
    logic out_negative;
    logic out_over;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_digits <= {4{`RESET_DIGIT}};
        end else if (enc_done && state == st_encoding) begin
            // Latches change only at the end of a conversion
            if (cap_over) begin
                out_digits <= {4{`OVR_DIGIT}};
            end else begin
                out_digits <= enc_digits;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_negative <= 1'b0;
        end else if (enc_done && state == st_encoding) begin
            out_negative <= cap_negative && !cap_over;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_over <= 1'b0;
        end else if (enc_done && state == st_encoding) begin
            out_over <= cap_over;
        end
    end

    // Done falls with the start and rises once the latches hold new data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conversion_done <= 1'b0;
        end else if (state == st_idle && start_req) begin
            conversion_done <= 1'b0;
        end else if (state != st_idle && restart_req) begin
            conversion_done <= 1'b0;
        end else if (state == st_encoding && enc_done) begin
            conversion_done <= 1'b1;
        end
    end

    // ****************************************************************
    // Digit selection
    // ****************************************************************
    function automatic logic [3:0] pick_digit(input digits_s d, input logic [1:0] sel);
        logic [3:0] nib;
        nib = d.d1;
        case (sel)
            2'h0: nib = d.d1;
            2'h1: nib = d.d2;
            2'h2: nib = d.d3;
            2'h3: nib = d.d4;
            default: nib = d.d1;
        endcase
        return nib;
    endfunction : pick_digit

    logic [1:0] held_addr;
    logic [1:0] pin_sel;

    // Address held while the latch enable is high, flows when low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            held_addr <= 2'h0;
        end else if (!dle_sync[1]) begin
            held_addr <= addr_sync;
        end
    end

    assign pin_sel = dle_sync[1] ? held_addr : addr_sync;

    // ****************************************************************
    // Pin outputs
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            digit_out <= `RESET_DIGIT;
        end else begin
            digit_out <= pick_digit(out_digits, pin_sel);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sign_out <= 1'b1;
        end else begin
            sign_out <= !out_negative;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overrange_flag <= 1'b0;
        end else begin
            overrange_flag <= out_over;
        end
    end

    // ****************************************************************
    // Host data bus driver
    // ****************************************************************
    logic [7:0] read_byte;

    always_comb begin
        read_byte = {4'h0, pick_digit(out_digits, host_req.addr[1:0])};
        if (host_req.addr[1:0] == `SEL_DIGIT4) begin
            read_byte[`OFL_BIT] = out_over;
            read_byte[`SIGN_BIT] = !out_negative;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_rdata <= 8'h00;
            host_rdata_oe <= 1'b0;
        end else begin
            host_rdata_oe <= host_read;
            if (host_read) begin
                host_rdata <= read_byte;
            end else begin
                host_rdata <= 8'h00;
            end
        end
    end

endmodule : bcd_adc_host_port

`default_nettype wire

// file: dv/bcd_adc_host_port_props.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker
// ****
module bcd_adc_host_port_props #(
    parameter int unsigned CONV_CYCLES = 50,
    parameter logic [5:0] PORT_BASE = 6'h10
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic conversion_trigger,
    input wire bcd_adc_pkg::host_req_s host_req,
    input wire logic [3:0] digit_out,
    input wire logic sign_out,
    input wire logic overrange_flag,
    input wire logic conversion_done,
    input wire logic [7:0] host_rdata,
    input wire logic host_rdata_oe
);
    localparam int MAX_WAIT = CONV_CYCLES + 100;
    logic hit;
    logic trig_quiet;
    assign hit = host_req.addr[7:2] == PORT_BASE;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trig_quiet <= 1'b0;
        end else begin
            trig_quiet <= 1'b1;
        end
    end
    read_answer_a: assert property (host_req.rd && hit |=> host_rdata_oe)
        else $error("decoded read not answered");
    stray_drive_a: assert property (!(host_req.rd && hit) |=> !host_rdata_oe)
        else $error("bus driven without decoded read");
    idle_bus_a: assert property (!host_rdata_oe |-> host_rdata == 8'h00)
        else $error("read data not zero while idle");
    low_byte_a: assert property (host_req.rd && hit && host_req.addr[1:0] != 2'h3
        |=> host_rdata[7:4] == 4'h0) else $error("upper nibble set on low digit");
    done_drop_a: assert property (host_req.wr && hit && conversion_done
        |=> !conversion_done) else $error("done did not drop on start");
    done_hold_a: assert property (conversion_done && !(host_req.wr && hit)
        && !conversion_trigger && !$past(conversion_trigger) && !$past(conversion_trigger, 2)
        && !$past(conversion_trigger, 3) |=> conversion_done)
        else $error("done dropped without a start");
    ovr_code_a: assert property (overrange_flag |-> digit_out == 4'hE && sign_out)
        else $error("overrange code wrong");
    bcd_range_a: assert property (!overrange_flag |-> digit_out <= 4'h9)
        else $error("digit not BCD");
    done_low_a: assert property ($fell(conversion_done) |-> (!conversion_done)[*8])
        else $error("done high too soon");
    done_bound_a: assert property ($fell(conversion_done)
        |-> ##[1:MAX_WAIT] conversion_done) else $error("conversion too long");
    cover property (host_req.rd && hit ##1 host_rdata_oe);
    cover property ($rose(conversion_done) && trig_quiet);
    cover property ($rose(overrange_flag));
endmodule : bcd_adc_host_port_props

bind bcd_adc_host_port bcd_adc_host_port_props #(
    .CONV_CYCLES(CONV_CYCLES),
    .PORT_BASE(PORT_BASE)
) chk (.ref_clk, .rst, .conversion_trigger, .host_req, .digit_out, .sign_out,
    .overrange_flag, .conversion_done, .host_rdata, .host_rdata_oe);
`default_nettype wire

// file: dv/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Host processor
// ****
module host_model (
    input wire logic ref_clk,
    input wire logic [7:0] host_rdata,
    input wire logic host_rdata_oe,
    output var bcd_adc_pkg::host_req_s host_req
);
    import bcd_adc_pkg::*;
    initial host_req = '0;
    // Output write to the port starts a conversion
    task automatic wr(input logic [7:0] a);
        @(posedge ref_clk);
        host_req <= '{a, 8'hA5, 1'b1, 1'b0};
        @(posedge ref_clk);
        host_req <= '0;
    endtask : wr
    // Returns drive enable above the byte
    task automatic rd(input logic [7:0] a, output logic [8:0] d);
        @(posedge ref_clk);
        host_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        host_req <= '0;
        #1 d = {host_rdata_oe, host_rdata};
    endtask : rd
    // Service after done: top digit first, then the three lower digits, one read each
    task automatic service(input logic [5:0] base, output logic err, output logic [15:0] w);
        logic [8:0] b;
        logic [3:0] top;
        rd({base, 2'h3}, b);
        err = b[7];
        top = b[3:0];
        if (!err && !b[6]) begin
            top[3] = 1'b1;
        end
        w[15:12] = top;
        rd({base, 2'h2}, b);
        w[11:8] = b[3:0];
        rd({base, 2'h1}, b);
        w[7:4] = b[3:0];
        rd({base, 2'h0}, b);
        w[3:0] = b[3:0];
    endtask : service
endmodule : host_model
`default_nettype wire

// file: dv/bcd_adc_host_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Testbench
// ****
module bcd_adc_host_port_tb;
    import bcd_adc_pkg::*;
    localparam logic [7:0] BASE = 8'h40;
    logic ref_clk, rst, conversion_trigger, digit_latch_enable, sign_out, overrange_flag;
    logic conversion_done, host_rdata_oe;
    logic [1:0] digit_address;
    logic [3:0] digit_out;
    logic [7:0] host_rdata;
    logic [8:0] d;
    sample_s sample;
    host_req_s host_req;
    int miscompares = 0;
    int total_checks = 0;

    bcd_adc_host_port #(.CONV_CYCLES(50)) uut (.ref_clk, .rst, .conversion_trigger,
        .digit_latch_enable, .digit_address, .sample, .host_req, .digit_out, .sign_out,
        .overrange_flag, .conversion_done, .host_rdata, .host_rdata_oe);
    host_model host (.ref_clk, .host_rdata, .host_rdata_oe, .host_req);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("Checks %0d, miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic wait_done;
        int n;
        n = 0;
        while (conversion_done !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(conversion_done, 1'b1);
        repeat (3) @(posedge ref_clk);
    endtask : wait_done

    task automatic pin_digit(input logic [1:0] a, input logic [3:0] exp);
        @(posedge ref_clk);
        digit_address <= a;
        repeat (6) @(posedge ref_clk);
        chk(digit_out, exp);
    endtask : pin_digit

    task automatic conv_read(input logic neg, input logic [11:0] mag, input logic ovr);
        logic [15:0] e;
        logic err;
        logic [15:0] w;
        e = ovr ? 16'hEEEE : {4'(mag / 1000), 4'(mag / 100 % 10), 4'(mag / 10 % 10), 4'(mag % 10)};
        @(posedge ref_clk);
        sample <= '{neg, mag};
        host.wr(BASE);
        repeat (2) @(posedge ref_clk);
        chk(conversion_done, 1'b0);
        wait_done();
        chk({overrange_flag, sign_out}, {ovr, ovr | !neg});
        for (int i = 0; i < 3; i++) begin
            host.rd(BASE + 8'(i), d);
            chk(d, {5'h10, e[i*4 +: 4]});
        end
        host.rd(BASE + 8'h03, d);
        chk(d, {1'b1, ovr, ovr | !neg, 2'b00, e[15:12]});
        for (int i = 0; i < 4; i++) begin
            pin_digit(2'(i), e[i*4 +: 4]);
        end
        host.service(BASE[7:2], err, w);
        chk(16'(err), 16'(ovr));
        chk(w, {e[15] | neg, e[14:0]});
    endtask : conv_read

    task automatic latch_hold;
        pin_digit(2'h3, 4'h1);
        digit_latch_enable <= 1'b1;
        repeat (6) @(posedge ref_clk);
        pin_digit(2'h0, 4'h1);
        digit_latch_enable <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(digit_out, 4'h4);
    endtask : latch_hold

    task automatic foreign_addr;
        host.rd(8'h20, d);
        chk(d, 9'h000);
        host.wr(8'h3C);
        repeat (4) @(posedge ref_clk);
        chk(conversion_done, 1'b1);
    endtask : foreign_addr

    task automatic pin_pulse;
        sample <= '{1'b0, 12'd1500};
        conversion_trigger <= 1'b1;
        @(posedge ref_clk);
        conversion_trigger <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(conversion_done, 1'b0);
        chk(digit_out, 4'h0);
        wait_done();
        chk(digit_out, 4'h1);
    endtask : pin_pulse

    task automatic pin_level;
        conversion_trigger <= 1'b1;
        repeat (6) @(posedge ref_clk);
        wait_done();
        sample <= '{1'b0, 12'd321};
        repeat (8) @(posedge ref_clk);
        chk(conversion_done, 1'b0);
        wait_done();
        chk(digit_out, 4'h0);
        conversion_trigger <= 1'b0;
    endtask : pin_level

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #200000;
        miscompares++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        conversion_trigger = 1'b0;
        digit_latch_enable = 1'b0;
        digit_address = 2'h0;
        sample = '0;
        repeat (8) @(posedge ref_clk);
        chk({digit_out, sign_out, overrange_flag, conversion_done, host_rdata_oe}, 8'h08);
        rst <= 1'b0;
        conv_read(1'b0, 12'd1234, 1'b0);
        latch_hold();
        conv_read(1'b1, 12'd1999, 1'b0);
        conv_read(1'b0, 12'd2000, 1'b0 | 1'b1);
        conv_read(1'b1, 12'hFFF, 1'b1);
        conv_read(1'b1, 12'd0, 1'b0);
        foreign_addr();
        pin_pulse();
        pin_level();
        test_done();
    end
endmodule : bcd_adc_host_port_tb
`default_nettype wire
